// ### hw/pwrcsr_top.sv
// power control status and converter configuration register block
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "pwrcsr_consts.svh"
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module pwrcsr_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	input wire pwrcsr_pkg::pwrcsr_seq_state_t seq_state,
	input wire pwrcsr_pkg::pwrcsr_applied_t applied,
	input wire logic [6:0] boot_vcode,
	input wire logic osc_stable,
	input wire logic pll_rail_good,
	input wire logic core_rail_good,
	input wire logic [1:0] conv_limiting,
	input wire logic [1:0] conv_softstart,
	output logic [1:0] pg_level,
	output logic err_clear,
	output logic [1:0] ana_ilimit,
	output logic [1:0] core_ilimit,
	output logic [1:0] ana_clk_sel,
	output logic [1:0] core_clk_sel,
	output logic [6:0] core_vcode
);
	import pwrcsr_pkg::*;

	// ---------------------------------------------------------------
	// state record
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0] rst_sync;
		logic boot_done;
		logic [13:0] pin_s1;
		logic [13:0] pin_s2;
		logic [3:0] prev_en;
		pwrcsr_seq_state_t last_state;
		logic [3:0] en_seen;
		logic [1:0] pg;
		logic clr;
		logic [1:0] alim;
		logic [1:0] aclk;
		logic [1:0] clim;
		logic [1:0] cclk;
		logic [6:0] vcode;
		logic [3:0] ists;
		logic [3:0] imask;
		logic [3:0] health_d;
		logic [31:0] rdata;
		logic irq;
	} pwrcsr_state_t;

	pwrcsr_state_t s_reg;
	pwrcsr_state_t s_next;
	logic rst_sync_n;
	logic [13:0] pin_raw;
	logic [3:0] health_now;
	logic [3:0] ev;
	logic [31:0] seq_word;
	logic [31:0] conv_word;
	logic [31:0] hlt_word;

	// release is seen after two flops; a third would only delay boot load
	assign rst_sync_n = s_reg.rst_sync[1];

	// status pins from analogue side, grouped for the synchroniser
	assign pin_raw = {boot_vcode, osc_stable, pll_rail_good,
		core_rail_good, conv_limiting, conv_softstart};
	// health events: rail lost, current limit entered
	assign health_now = {~s_reg.pin_s2[5], ~s_reg.pin_s2[4],
		s_reg.pin_s2[3], s_reg.pin_s2[2]};
	assign ev = health_now & ~s_reg.health_d;

	// ---------------------------------------------------------------
	// read words
	// ---------------------------------------------------------------
	always_comb begin
		seq_word = 32'h0;
		seq_word[`PWRCSR_SEQ_STATE_LSB +: 3] = seq_state;
		seq_word[`PWRCSR_SEQ_PREV_IO] = s_reg.prev_en[3];
		seq_word[`PWRCSR_SEQ_PREV_PLL] = s_reg.prev_en[2];
		seq_word[`PWRCSR_SEQ_PREV_ANA] = s_reg.prev_en[1];
		seq_word[`PWRCSR_SEQ_PREV_CORE] = s_reg.prev_en[0];
		seq_word[`PWRCSR_SEQ_TILE_OFF] = applied.tile_clk_off;
		seq_word[`PWRCSR_SEQ_MOD_ANA] = applied.mod_ana;
		seq_word[`PWRCSR_SEQ_MOD_CORE] = applied.mod_core;
		seq_word[`PWRCSR_SEQ_EN_IO] = applied.en[3];
		seq_word[`PWRCSR_SEQ_EN_PLL] = applied.en[2];
		seq_word[`PWRCSR_SEQ_EN_ANA] = applied.en[1];
		seq_word[`PWRCSR_SEQ_EN_CORE] = applied.en[0];
		conv_word = 32'h0;
		conv_word[`PWRCSR_CONV_PG_LSB +: 2] = s_reg.pg;
		conv_word[`PWRCSR_CONV_CLR_BIT] = s_reg.clr;
		conv_word[`PWRCSR_CONV_ALIM_LSB +: 2] = s_reg.alim;
		conv_word[`PWRCSR_CONV_ACLK_LSB +: 2] = s_reg.aclk;
		conv_word[`PWRCSR_CONV_CLIM_LSB +: 2] = s_reg.clim;
		conv_word[`PWRCSR_CONV_CCLK_LSB +: 2] = s_reg.cclk;
		hlt_word = 32'h0;
		hlt_word[`PWRCSR_HLT_OSC] = s_reg.pin_s2[6];
		hlt_word[`PWRCSR_HLT_PLL_GOOD] = s_reg.pin_s2[5];
		hlt_word[`PWRCSR_HLT_CORE_GOOD] = s_reg.pin_s2[4];
		hlt_word[`PWRCSR_HLT_LIM_ANA] = s_reg.pin_s2[3];
		hlt_word[`PWRCSR_HLT_LIM_CORE] = s_reg.pin_s2[2];
		hlt_word[`PWRCSR_HLT_SS_ANA] = s_reg.pin_s2[1];
		hlt_word[`PWRCSR_HLT_SS_CORE] = s_reg.pin_s2[0];
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.rst_sync = {s_reg.rst_sync[0], 1'b1};
		s_next.pin_s1 = pin_raw;
		s_next.pin_s2 = s_reg.pin_s1;
		s_next.health_d = health_now;
		// previous-state enables latch when the sequencer moves on
		s_next.last_state = seq_state;
		s_next.en_seen = applied.en;
		if (seq_state != s_reg.last_state) begin
			s_next.prev_en = s_reg.en_seen;
		end
		// boot code caught once the synchronised pins are valid
		if (!s_reg.boot_done) begin
			s_next.boot_done = 1'b1;
			s_next.vcode = s_reg.pin_s2[13:7];
		end
		if (reg_wr) begin
			if (reg_addr == `PWRCSR_OFF_CONV) begin
				s_next.pg = reg_wdata[`PWRCSR_CONV_PG_LSB +: 2];
				s_next.clr = reg_wdata[`PWRCSR_CONV_CLR_BIT];
				s_next.alim = reg_wdata[`PWRCSR_CONV_ALIM_LSB +: 2];
				s_next.aclk = reg_wdata[`PWRCSR_CONV_ACLK_LSB +: 2];
				s_next.clim = reg_wdata[`PWRCSR_CONV_CLIM_LSB +: 2];
				s_next.cclk = reg_wdata[`PWRCSR_CONV_CCLK_LSB +: 2];
			end else if (reg_addr == `PWRCSR_OFF_VCORE) begin
				s_next.vcode = reg_wdata[6:0];
			end else if (reg_addr == `PWRCSR_OFF_IRQ_MASK) begin
				s_next.imask = reg_wdata[3:0];
			end else if (reg_addr == `PWRCSR_OFF_IRQ_STAT) begin
				s_next.ists = s_reg.ists & ~reg_wdata[3:0];
			end
			// other offsets, incl. read-only reports, are ignored
		end
		// set wins over a same-cycle write-one clear
		s_next.ists = s_next.ists | ev;
		s_next.rdata = 32'h0;
		if (reg_rd) begin
			if (reg_addr == `PWRCSR_OFF_SEQ) begin
				s_next.rdata = seq_word;
			end else if (reg_addr == `PWRCSR_OFF_CONV) begin
				s_next.rdata = conv_word;
			end else if (reg_addr == `PWRCSR_OFF_HEALTH) begin
				s_next.rdata = hlt_word;
			end else if (reg_addr == `PWRCSR_OFF_VCORE) begin
				s_next.rdata = {25'h0, s_reg.vcode};
			end else if (reg_addr == `PWRCSR_OFF_IRQ_STAT) begin
				s_next.rdata = {28'h0, s_reg.ists};
			end else if (reg_addr == `PWRCSR_OFF_IRQ_MASK) begin
				s_next.rdata = {28'h0, s_reg.imask};
			end
		end
		s_next.irq = |(s_next.ists & s_next.imask);
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.prev_en <= `PWRCSR_PREV_RESET;
			s_reg.pg <= `PWRCSR_PG_RESET;
			s_reg.alim <= `PWRCSR_LIM_RESET;
			s_reg.clim <= `PWRCSR_LIM_RESET;
			s_reg.aclk <= `PWRCSR_CLK_RESET;
			s_reg.cclk <= `PWRCSR_CLK_RESET;
		end else if (!rst_sync_n) begin
			// hold control at reset values until release is synchronised
			s_reg.rst_sync <= s_next.rst_sync;
			s_reg.pin_s1 <= s_next.pin_s1;
			s_reg.pin_s2 <= s_next.pin_s2;
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs straight from flops
	assign reg_rdata = s_reg.rdata;
	assign irq = s_reg.irq;
	assign pg_level = s_reg.pg;
	assign err_clear = s_reg.clr;
	assign ana_ilimit = s_reg.alim;
	assign core_ilimit = s_reg.clim;
	assign ana_clk_sel = s_reg.aclk;
	assign core_clk_sel = s_reg.cclk;
	assign core_vcode = s_reg.vcode;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_conv_write;
		@(posedge mclk) disable iff (!rst_sync_n)
		reg_wr && reg_addr == `PWRCSR_OFF_CONV |=> pg_level ==
			$past(reg_wdata[25:24]) && core_clk_sel == $past(reg_wdata[1:0]);
	endproperty
	a_conv_write: assert property (p_conv_write)
		else $error("converter config write not applied");

	property p_clr_sticky;
		@(posedge mclk) disable iff (!rst_sync_n)
		err_clear && !(reg_wr && reg_addr == `PWRCSR_OFF_CONV) |=> err_clear;
	endproperty
	a_clr_sticky: assert property (p_clr_sticky)
		else $error("error clear dropped by itself");

	property p_seq_read;
		@(posedge mclk) disable iff (!rst_sync_n)
		reg_rd && reg_addr == `PWRCSR_OFF_SEQ |=>
			reg_rdata[18:16] == $past(seq_state) && reg_rdata[15] == 1'b0;
	endproperty
	a_seq_read: assert property (p_seq_read)
		else $error("sequence state read wrong");

	property p_vcode_write;
		@(posedge mclk) disable iff (!rst_sync_n)
		reg_wr && reg_addr == `PWRCSR_OFF_VCORE |=>
			core_vcode == $past(reg_wdata[6:0]);
	endproperty
	a_vcode_write: assert property (p_vcode_write)
		else $error("core code write not applied");

	property p_ro_write;
		@(posedge mclk) disable iff (!rst_sync_n)
		reg_wr && reg_addr == `PWRCSR_OFF_HEALTH |=> $stable(core_vcode)
			&& $stable(pg_level) && $stable(ana_ilimit);
	endproperty
	a_ro_write: assert property (p_ro_write)
		else $error("read-only write changed state");

	property p_hlt_read;
		@(posedge mclk) disable iff (!rst_sync_n)
		reg_rd && reg_addr == `PWRCSR_OFF_HEALTH |=>
			reg_rdata[31:25] == 7'h0 && reg_rdata[24] == $past(s_reg.pin_s2[6]);
	endproperty
	a_hlt_read: assert property (p_hlt_read)
		else $error("health read wrong");

	property p_lim_write;
		@(posedge mclk) disable iff (!rst_sync_n)
		reg_wr && reg_addr == `PWRCSR_OFF_CONV |=> ana_ilimit ==
			$past(reg_wdata[14:13]) && core_ilimit == $past(reg_wdata[6:5]);
	endproperty
	a_lim_write: assert property (p_lim_write)
		else $error("current limit write not applied");

	property p_prev_en;
		@(posedge mclk) disable iff (!rst_sync_n)
		seq_state != s_reg.last_state |=> s_reg.prev_en == $past(s_reg.en_seen);
	endproperty
	a_prev_en: assert property (p_prev_en)
		else $error("previous enables not captured");

	// register access steps used by the checks below
	sequence s_rd_seq;
		reg_rd && reg_addr == `PWRCSR_OFF_SEQ;
	endsequence
	sequence s_rd_health;
		reg_rd && reg_addr == `PWRCSR_OFF_HEALTH;
	endsequence
	sequence s_wr_conv;
		reg_wr && reg_addr == `PWRCSR_OFF_CONV;
	endsequence
	// clear with no event beside it, so nothing may win over it
	sequence s_stat_clear;
		reg_wr && reg_addr == `PWRCSR_OFF_IRQ_STAT && ev == 4'h0;
	endsequence

	property p_seq_enables;
		@(posedge mclk) disable iff (!rst_sync_n)
		s_rd_seq |=> reg_rdata[5:4] == $past(applied.en[3:2])
			&& reg_rdata[1:0] == $past(applied.en[1:0])
			&& reg_rdata[14] == $past(applied.tile_clk_off);
	endproperty
	a_seq_enables: assert property (p_seq_enables)
		else $error("applied settings read wrong");

	property p_hlt_rails;
		@(posedge mclk) disable iff (!rst_sync_n)
		s_rd_health |=> reg_rdata[19] == $past(s_reg.pin_s2[5])
			&& reg_rdata[16] == $past(s_reg.pin_s2[4]);
	endproperty
	a_hlt_rails: assert property (p_hlt_rails)
		else $error("rail good bits read wrong");

	property p_clk_write;
		@(posedge mclk) disable iff (!rst_sync_n)
		s_wr_conv |=> ana_clk_sel == $past(reg_wdata[9:8])
			&& err_clear == $past(reg_wdata[16]);
	endproperty
	a_clk_write: assert property (p_clk_write)
		else $error("analogue clock or error clear not applied");

	// boot code lands once, unless software writes the code in that same cycle
	property p_boot_load;
		@(posedge mclk) disable iff (!rst_sync_n)
		!s_reg.boot_done
			&& !(reg_wr && reg_addr == `PWRCSR_OFF_VCORE)
			|=> core_vcode == $past(s_reg.pin_s2[13:7]);
	endproperty
	a_boot_load: assert property (p_boot_load)
		else $error("boot code not loaded");

	property p_w1c;
		@(posedge mclk) disable iff (!rst_sync_n)
		s_stat_clear |=> (s_reg.ists & $past(reg_wdata[3:0])) == 4'h0;
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("status bits not cleared by a one");

	// a clear in the same cycle as an event must not lose the event
	property p_set_wins;
		@(posedge mclk) disable iff (!rst_sync_n)
		ev != 4'h0 |=> (s_reg.ists & $past(ev)) == $past(ev);
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("event lost against a status clear");

	// unmasked event raises the line next cycle; a mask write may veto it
	property p_irq_event;
		@(posedge mclk) disable iff (!rst_sync_n)
		(|(ev & s_reg.imask)) && !reg_wr |=> irq;
	endproperty
	a_irq_event: assert property (p_irq_event)
		else $error("interrupt not raised by unmasked event");
endmodule : pwrcsr_top

// ### hw/pwrcsr_consts.svh
// register offsets, field positions and reset values of the power control regs
`ifndef PWRCSR_CONSTS_SVH
`define PWRCSR_CONSTS_SVH

// register byte offsets
`define PWRCSR_OFF_SEQ 8'h24
`define PWRCSR_OFF_CONV 8'h2C
`define PWRCSR_OFF_HEALTH 8'h30
`define PWRCSR_OFF_VCORE 8'h34
`define PWRCSR_OFF_IRQ_STAT 8'h38
`define PWRCSR_OFF_IRQ_MASK 8'h3C

// converter configuration fields
`define PWRCSR_CONV_PG_LSB 24
`define PWRCSR_CONV_CLR_BIT 16
`define PWRCSR_CONV_ALIM_LSB 13
`define PWRCSR_CONV_ACLK_LSB 8
`define PWRCSR_CONV_CLIM_LSB 5
`define PWRCSR_CONV_CCLK_LSB 0
`define PWRCSR_PG_RESET 2'h2
`define PWRCSR_LIM_RESET 2'h0
`define PWRCSR_CLK_RESET 2'h1

// sequence report fields
`define PWRCSR_SEQ_STATE_LSB 16
`define PWRCSR_SEQ_PREV_IO 29
`define PWRCSR_SEQ_PREV_PLL 28
`define PWRCSR_SEQ_PREV_ANA 25
`define PWRCSR_SEQ_PREV_CORE 24
`define PWRCSR_PREV_RESET 4'h2
`define PWRCSR_SEQ_TILE_OFF 14
`define PWRCSR_SEQ_MOD_ANA 9
`define PWRCSR_SEQ_MOD_CORE 8
`define PWRCSR_SEQ_EN_IO 5
`define PWRCSR_SEQ_EN_PLL 4
`define PWRCSR_SEQ_EN_ANA 1
`define PWRCSR_SEQ_EN_CORE 0

// supply health fields
`define PWRCSR_HLT_OSC 24
`define PWRCSR_HLT_PLL_GOOD 19
`define PWRCSR_HLT_CORE_GOOD 16
`define PWRCSR_HLT_LIM_ANA 9
`define PWRCSR_HLT_LIM_CORE 8
`define PWRCSR_HLT_SS_ANA 1
`define PWRCSR_HLT_SS_CORE 0

// interrupt bit count and code width
`define PWRCSR_NIRQ 4
`define PWRCSR_VCODE_W 7

`endif

// ### hw/pwrcsr_pkg.sv
// types shared by the power control register block
package pwrcsr_pkg;
	typedef enum logic [2:0] {
		PWRCSR_ST_RESET = 3'b000,
		PWRCSR_ST_ASLEEP = 3'b001,
		PWRCSR_ST_WAKING1 = 3'b010,
		PWRCSR_ST_WAKING2 = 3'b011,
		PWRCSR_ST_AWAKE_WAIT = 3'b100,
		PWRCSR_ST_AWAKE = 3'b101,
		PWRCSR_ST_SLEEPING1 = 3'b110,
		PWRCSR_ST_SLEEPING2 = 3'b111
	} pwrcsr_seq_state_t;

	// settings applied to the supplies; order io, pll, ana, core
	typedef struct packed {
		logic tile_clk_off;
		logic mod_ana;
		logic mod_core;
		logic [3:0] en;
	} pwrcsr_applied_t;
endpackage : pwrcsr_pkg

// ### verification/pwrcsr_supply_model.sv
// behavioural supply side: sequencer, converters, rails and oscillator
`timescale 1ns/1ps
module pwrcsr_supply_model #(
	parameter logic [6:0] BOOT_CODE = 7'h2A
) (
	input wire logic err_clear,
	input wire logic [2:0] st_req,
	input wire logic [6:0] app_req,
	input wire logic osc_req,
	input wire logic pll_req,
	input wire logic core_req,
	input wire logic [1:0] lim_req,
	input wire logic [1:0] ss_req,
	output pwrcsr_pkg::pwrcsr_seq_state_t seq_state,
	output pwrcsr_pkg::pwrcsr_applied_t applied,
	output logic [6:0] boot_vcode,
	output logic osc_stable,
	output logic pll_rail_good,
	output logic core_rail_good,
	output logic [1:0] conv_limiting,
	output logic [1:0] conv_softstart
);
	import pwrcsr_pkg::*;
	// levels follow the bench's requests; there is no clock, seq_state comes straight from st_req
	assign seq_state = pwrcsr_seq_state_t'(st_req);
	assign applied = pwrcsr_applied_t'(app_req);
	assign boot_vcode = BOOT_CODE;
	assign osc_stable = osc_req;
	assign pll_rail_good = pll_req;
	assign core_rail_good = core_req;
	// a held error clear keeps the limiting flags down
	assign conv_limiting = err_clear ? 2'h0 : lim_req;
	assign conv_softstart = ss_req;
endmodule : pwrcsr_supply_model

// ### verification/pwrcsr_top_test.sv
// self-checking bench for the power control register block
`timescale 1ns/1ps
`include "pwrcsr_consts.svh"
module pwrcsr_top_test;
	import pwrcsr_pkg::*;
	localparam logic [6:0] BOOT = 7'h2A;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, rd_val, v;
	logic irq, err_clear;
	logic [1:0] pg_level, ana_ilimit, core_ilimit, ana_clk_sel, core_clk_sel;
	logic [6:0] core_vcode, boot_vcode, a;
	logic [6:0] app_req = 7'h00;
	logic [2:0] st_req = 3'h0;
	logic osc_req = 1'b0;
	logic pll_req = 1'b1;
	logic core_req = 1'b1;
	logic [1:0] lim_req = 2'h0;
	logic [1:0] ss_req = 2'h0;
	pwrcsr_seq_state_t seq_state;
	pwrcsr_applied_t applied;
	logic osc_stable, pll_rail_good, core_rail_good;
	logic [1:0] conv_limiting, conv_softstart;
	int fail_count = 0;
	int n_tests = 0;

	pwrcsr_top dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .seq_state(seq_state),
		.applied(applied), .boot_vcode(boot_vcode), .osc_stable(osc_stable),
		.pll_rail_good(pll_rail_good), .core_rail_good(core_rail_good),
		.conv_limiting(conv_limiting), .conv_softstart(conv_softstart),
		.pg_level(pg_level), .err_clear(err_clear), .ana_ilimit(ana_ilimit),
		.core_ilimit(core_ilimit), .ana_clk_sel(ana_clk_sel),
		.core_clk_sel(core_clk_sel), .core_vcode(core_vcode));
	pwrcsr_supply_model #(.BOOT_CODE(BOOT)) supply (.err_clear(err_clear),
		.st_req(st_req), .app_req(app_req), .osc_req(osc_req),
		.pll_req(pll_req), .core_req(core_req), .lim_req(lim_req),
		.ss_req(ss_req), .seq_state(seq_state), .applied(applied),
		.boot_vcode(boot_vcode), .osc_stable(osc_stable),
		.pll_rail_good(pll_rail_good), .core_rail_good(core_rail_good),
		.conv_limiting(conv_limiting), .conv_softstart(conv_softstart));

	// ---------------------------------------------------------------
	// bus cycles and comparison
	// ---------------------------------------------------------------
	initial begin
		forever #10 mclk = ~mclk;
	end
	task automatic chk(input string what, input logic [31:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] ad);
		@(posedge mclk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask : rd
	function automatic logic [31:0] pins();
		return {21'h0, pg_level, ana_ilimit, ana_clk_sel, core_ilimit,
			core_clk_sel, err_clear};
	endfunction : pins
	function automatic logic [31:0] seq_exp(logic [6:0] p, c, logic [2:0] s);
		return {2'h0, p[3:2], 2'h0, p[1:0], 5'h00, s, 1'b0, c[6], 4'h0,
			c[5:4], 2'h0, c[3:2], 2'h0, c[1:0]};
	endfunction : seq_exp

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		rd(`PWRCSR_OFF_CONV);
		chk("conv reset", 32'h0200_0101, rd_val);
		chk("conv pins", {21'h0, 11'h422}, pins());
		rd(`PWRCSR_OFF_SEQ);
		chk("seq reset", 32'h0200_0000, rd_val);
		rd(`PWRCSR_OFF_VCORE);
		chk("vcode reset", {25'h0, BOOT}, rd_val);
	endtask : t_reset
	// every code of every field, reserved bits written as ones
	task automatic t_conv();
		for (int k = 0; k < 4; k++) begin
			v = {6'h0, k[1:0], 8'h00, 1'b0, k[1:0], 3'h0, k[1:0], 1'b0,
				k[1:0], 3'h0, k[1:0]};
			wr(`PWRCSR_OFF_CONV, v | 32'hFCFE_9C9C);
			chk("conv pins", {21'h0, {5{k[1:0]}}, 1'b0}, pins());
			rd(`PWRCSR_OFF_CONV);
			chk("conv read", v, rd_val);
		end
		wr(`PWRCSR_OFF_CONV, 32'h0001_0000);
		repeat (8) @(posedge mclk);
		chk("err clear held", 32'h1, {31'h0, err_clear});
		wr(`PWRCSR_OFF_CONV, 32'h0000_0000);
		chk("err clear off", 32'h0, {31'h0, err_clear});
	endtask : t_conv
	// prev enables latch at a state change, not at later supply changes
	task automatic t_seq();
		for (int i = 1; i < 9; i++) begin
			a = 7'(i * 53);
			app_req <= a;
			repeat (3) @(posedge mclk);
			st_req <= 3'(i);
			repeat (3) @(posedge mclk);
			app_req <= ~a;
			repeat (3) @(posedge mclk);
			rd(`PWRCSR_OFF_SEQ);
			chk("seq report", seq_exp(a, ~a, 3'(i)), rd_val);
		end
		wr(`PWRCSR_OFF_SEQ, 32'hFFFF_FFFF);
		rd(`PWRCSR_OFF_SEQ);
		chk("seq ro", seq_exp(a, ~a, 3'h0), rd_val);
	endtask : t_seq
	task automatic t_health();
		for (int j = 0; j < 7; j++) begin
			v = 32'h1 << j;
			{osc_req, pll_req, core_req, lim_req, ss_req} <= v[6:0];
			repeat (5) @(posedge mclk);
			rd(`PWRCSR_OFF_HEALTH);
			chk("health", {7'h0, v[6], 4'h0, v[5], 2'h0, v[4], 6'h0, v[3:2],
				6'h0, v[1:0]}, rd_val);
		end
		// the health report ignores writes; osc stays up from the last step
		wr(`PWRCSR_OFF_HEALTH, 32'hFFFF_FFFF);
		rd(`PWRCSR_OFF_HEALTH);
		chk("health ro", 32'h0100_0000, rd_val);
		{pll_req, core_req, lim_req, ss_req} <= 6'h30;
		repeat (5) @(posedge mclk);
		wr(`PWRCSR_OFF_IRQ_STAT, 32'h0000_000F);
	endtask : t_health
	// each event: set while masked, unmask, then clear by writing one
	task automatic t_irq();
		for (int b = 0; b < 4; b++) begin
			wr(`PWRCSR_OFF_IRQ_MASK, 32'h0000_0000);
			{pll_req, core_req, lim_req} <= 4'hC ^ (4'h1 << b);
			repeat (5) @(posedge mclk);
			chk("irq masked", 32'h0, {31'h0, irq});
			rd(`PWRCSR_OFF_IRQ_STAT);
			chk("irq status", 32'h1 << b, rd_val);
			wr(`PWRCSR_OFF_IRQ_MASK, 32'h1 << b);
			repeat (2) @(posedge mclk);
			chk("irq up", 32'h1, {31'h0, irq});
			wr(`PWRCSR_OFF_IRQ_STAT, 32'h1 << b);
			repeat (2) @(posedge mclk);
			chk("irq cleared", 32'h0, {31'h0, irq});
			{pll_req, core_req, lim_req} <= 4'hC;
			repeat (5) @(posedge mclk);
		end
	endtask : t_irq
	// one 10 mV step per microsecond, up to code 70
	task automatic t_vcode();
		for (int c = BOOT + 1; c <= 70; c++) begin
			wr(`PWRCSR_OFF_VCORE, {25'h1FF_FFFF, 7'(c)});
			chk("vcode pins", 32'(c), {25'h0, core_vcode});
			rd(`PWRCSR_OFF_VCORE);
			chk("vcode read", 32'(c), rd_val);
			repeat (50) @(posedge mclk);
		end
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40);
		chk("unmapped", 32'h0, rd_val);
		rd(`PWRCSR_OFF_CONV);
		chk("conv kept", 32'h0, rd_val);
	endtask : t_vcode

	// ---------------------------------------------------------------
	// sequence, watchdog and verdict
	// ---------------------------------------------------------------
	task automatic conclude();
		if (fail_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (6) @(posedge mclk);
		t_reset();
		t_conv();
		t_seq();
		t_health();
		t_irq();
		t_vcode();
		conclude();
	end
	// the whole run takes about 1800 cycles
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		conclude();
	end
endmodule : pwrcsr_top_test
